// file: core/memory_peripheral_bus_port.v
// Memory and peripheral bus port: access sequencer, bus hand-off and reset pin.
//
// Notes on behaviour
// - Names ending _n are active low.
// - Device drives the 26-bit address bus.
// - Module mode puts data masks on bits 20:17 of SDRAM accesses.
// - Data moves over the shared 32-bit bus.
// - Direction low during reads, high during writes.
// - Output enable zero low on device reads.
// - Output enable one low on SDRAM reads.
// - Grant low means the bus is given away.
// - Only the addressed device's select goes low.
// - Cold reset initialises state, loads boot configuration.
// - Reset pin driven low during reset, then released.
// - Buffered clock copy drives out, feedback returns.
`include "bus_port_defs.vh"
`timescale 1ns/10ps
`default_nettype none

module memory_peripheral_bus_port #(
  parameter ACCESS_CYCLES = `BP_ACCESS_MIN,
  parameter ACK_TIMEOUT   = `BP_ACK_TIMEOUT,
  parameter RST_HOLD      = `BP_RST_HOLD_CYC,
  parameter FB_TIMEOUT    = `BP_FB_TIMEOUT
) (
  input  wire                      clk,
  input  wire                      reset,
  // Internal request side.
  input  wire                      req_valid,
  input  wire                      req_write,
  input  wire                      req_sdram,
  input  wire [`BP_CS_IDX_W-1:0]   req_cs,
  input  wire [`BP_ADDR_W-1:0]     req_addr,
  input  wire [`BP_DATA_W-1:0]     req_wdata,
  input  wire [`BP_MASK_W-1:0]     req_mask,
  output wire                      req_ready,
  output wire                      rsp_done,
  output wire                      rsp_error,
  output wire [`BP_DATA_W-1:0]     rsp_rdata,
  // Configuration levels.
  input  wire                      sodimm_mode,
  input  wire                      wait_is_ack,
  input  wire [`BP_BOOT_W-1:0]     boot_strap,
  output wire [`BP_BOOT_W-1:0]     boot_cfg,
  output wire                      core_reset,
  output wire                      sdram_clock_ok,
  // Pins.
  output wire [`BP_ADDR_W-1:0]     mem_addr_bus,
  output wire                      mem_bus_oe,
  input  wire [`BP_DATA_W-1:0]     mem_data_in,
  output wire [`BP_DATA_W-1:0]     mem_data_out,
  output wire                      mem_data_oe,
  output wire                      xcvr_dir_n,
  output wire [1:0]                xcvr_out_en_n,
  output wire [`BP_CS_N-1:0]       chip_select_n,
  input  wire                      bus_request_n,
  output wire                      bus_grant_n,
  input  wire                      wait_or_ack_n,
  input  wire                      cold_reset_n,
  input  wire                      warm_reset_io_n_in,
  output wire                      warm_reset_io_n_out,
  output wire                      warm_reset_io_n_oe,
  output wire                      buffered_clock_out,
  input  wire                      sdram_clock_feedback
);

  localparam integer         ACCESS_LAST_I = ACCESS_CYCLES - 1;
  localparam [`BP_CNT_W-1:0] ACCESS_LAST   = ACCESS_LAST_I[`BP_CNT_W-1:0];
  localparam [`BP_CNT_W-1:0] ACK_LAST      = ACK_TIMEOUT[`BP_CNT_W-1:0];
  localparam [`BP_CNT_W-1:0] FB_LAST       = FB_TIMEOUT[`BP_CNT_W-1:0];
  localparam [`BP_CNT_W-1:0] CNT_ONE     = 8'h01;

  wire [`BP_PIN_W-1:0]  pins_q;
  wire [`BP_DATA_W-1:0] data_q;
  wire [`BP_BOOT_W-1:0] strap_q;
  wire                  rst_active;
  wire                  guard_active;
  wire                  cold_active;
  wire                  warm_seen;
  wire                  req_seen;
  wire                  wait_low;

  reg [2:0]             state_reg;
  reg [`BP_CNT_W-1:0]   cnt_reg;
  reg                   is_write_reg;
  reg                   is_sdram_reg;
  reg [`BP_ADDR_W-1:0]  addr_reg;
  reg                   bus_oe_reg;
  reg [`BP_DATA_W-1:0]  dout_reg;
  reg                   dout_oe_reg;
  reg                   dir_n_reg;
  reg [1:0]             oe_n_reg;
  reg [`BP_CS_N-1:0]    cs_n_reg;
  reg                   grant_n_reg;
  reg                   ready_reg;
  reg                   done_reg;
  reg                   error_reg;
  reg [`BP_DATA_W-1:0]  rdata_reg;
  reg [`BP_BOOT_W-1:0]  boot_reg;
  reg                   cold_prev_reg;
  reg                   warm_oe_reg;
  reg                   warm_out_reg;
  reg                   core_rst_reg;
  reg                   bclk_reg;
  reg                   fb_prev_reg;
  reg [`BP_CNT_W-1:0]   fb_cnt_reg;
  reg                   fb_ok_reg;
  reg [`BP_ADDR_W-1:0]  addr_next;

  // Every pin input passes two flip-flops before use.
  pin_sync #(.WIDTH(`BP_PIN_W), .INIT(`BP_PIN_INIT)) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({sdram_clock_feedback, warm_reset_io_n_in, cold_reset_n,
             wait_or_ack_n, bus_request_n}),
    .q     (pins_q)
  );

  pin_sync #(.WIDTH(`BP_DATA_W)) u_data_sync (
    .clk   (clk),
    .reset (reset),
    .d     (mem_data_in),
    .q     (data_q)
  );

  pin_sync #(.WIDTH(`BP_BOOT_W)) u_strap_sync (
    .clk   (clk),
    .reset (reset),
    .d     (boot_strap),
    .q     (strap_q)
  );

  // Pin levels decoded as active low.
  assign cold_active = ~pins_q[`BP_PIN_COLD];
  assign req_seen    = ~pins_q[`BP_PIN_REQ];
  assign wait_low    = ~pins_q[`BP_PIN_WAIT];
  // Our own drive of the reset pin reads back low, so it is masked.
  assign warm_seen   = ~pins_q[`BP_PIN_WARM] & ~guard_active;

  // Any reset source holds the port in reset and the pin low.
  pulse_stretch #(.HOLD(RST_HOLD), .CW(16)) u_rst_stretch (
    .clk     (clk),
    .reset   (reset),
    .trigger (cold_active | warm_seen),
    .active  (rst_active)
  );

  // Covers the pin drive and the time the pull-up needs to lift it.
  pulse_stretch #(.HOLD(`BP_GUARD_CYC), .CW(4)) u_guard (
    .clk     (clk),
    .reset   (reset),
    .trigger (warm_oe_reg),
    .active  (guard_active)
  );

  // Reset pin drive, core reset and boot configuration capture.
  always @(posedge clk) begin
    if (reset) begin
      warm_oe_reg   <= 1'b1;
      warm_out_reg  <= 1'b0;
      core_rst_reg  <= 1'b1;
      cold_prev_reg <= 1'b1;
      boot_reg      <= {`BP_BOOT_W{1'b0}};
    end else begin
      warm_oe_reg   <= rst_active;
      warm_out_reg  <= 1'b0;
      core_rst_reg  <= rst_active;
      cold_prev_reg <= cold_active;
      if (cold_prev_reg && !cold_active) begin
        boot_reg <= strap_q;
      end
    end
  end

  // Clock copy for the SDRAM and a watch on its returning feedback.
  always @(posedge clk) begin
    if (reset) begin
      bclk_reg    <= 1'b0;
      fb_prev_reg <= 1'b0;
      fb_cnt_reg  <= {`BP_CNT_W{1'b0}};
      fb_ok_reg   <= 1'b0;
    end else begin
      bclk_reg    <= ~bclk_reg;
      fb_prev_reg <= pins_q[`BP_PIN_FB];
      if (fb_prev_reg != pins_q[`BP_PIN_FB]) begin
        fb_cnt_reg <= {`BP_CNT_W{1'b0}};
        fb_ok_reg  <= 1'b1;
      end else if (fb_cnt_reg == FB_LAST) begin
        fb_ok_reg  <= 1'b0;
      end else begin
        fb_cnt_reg <= fb_cnt_reg + CNT_ONE;
      end
    end
  end

  // Address for a new access; module mode swaps in the mask enables on SDRAM accesses.
  always @* begin
    addr_next = req_addr;
    if (sodimm_mode && req_sdram) begin
      addr_next[`BP_MASK_HI:`BP_MASK_LO] = req_mask;
    end
  end

  // Access sequencer and bus hand-off; it goes idle as soon as any reset source fires.
  always @(posedge clk) begin
    if (core_rst_reg || rst_active) begin
      state_reg    <= `BP_ST_IDLE;
      cnt_reg      <= {`BP_CNT_W{1'b0}};
      is_write_reg <= 1'b0;
      is_sdram_reg <= 1'b0;
      addr_reg     <= {`BP_ADDR_W{1'b0}};
      bus_oe_reg   <= 1'b1;
      dout_reg     <= {`BP_DATA_W{1'b0}};
      dout_oe_reg  <= 1'b0;
      dir_n_reg    <= 1'b1;
      oe_n_reg     <= 2'b11;
      cs_n_reg     <= {`BP_CS_N{1'b1}};
      grant_n_reg  <= 1'b1;
      ready_reg    <= 1'b0;
      done_reg     <= 1'b0;
      error_reg    <= 1'b0;
      rdata_reg    <= {`BP_DATA_W{1'b0}};
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        `BP_ST_IDLE: begin
          if (req_seen) begin
            // The bus is idle here, so it can be handed over at once.
            state_reg   <= `BP_ST_GRANT;
            ready_reg   <= 1'b0;
            bus_oe_reg  <= 1'b0;
            grant_n_reg <= 1'b0;
          end else if (req_valid && ready_reg) begin
            state_reg    <= `BP_ST_SETUP;
            ready_reg    <= 1'b0;
            is_write_reg <= req_write;
            is_sdram_reg <= req_sdram;
            addr_reg     <= addr_next;
            dout_reg     <= req_wdata;
            dout_oe_reg  <= req_write;
            dir_n_reg    <= req_write;
            if (!req_sdram) begin
              cs_n_reg <= ~({{(`BP_CS_N-1){1'b0}}, 1'b1} << req_cs);
            end
          end else begin
            ready_reg <= 1'b1;
          end
        end
        `BP_ST_SETUP: begin
          state_reg <= `BP_ST_STROBE;
          cnt_reg   <= {`BP_CNT_W{1'b0}};
          if (!is_write_reg) begin
            oe_n_reg <= is_sdram_reg ? 2'b01 : 2'b10;
          end
        end
        `BP_ST_STROBE: begin
          cnt_reg <= cnt_reg + CNT_ONE;
          if ((wait_is_ack && wait_low) ||
              (!wait_is_ack && cnt_reg >= ACCESS_LAST && !wait_low) ||
              (wait_is_ack && cnt_reg == ACK_LAST)) begin
            state_reg <= `BP_ST_HOLD;
            oe_n_reg  <= 2'b11;
            cs_n_reg  <= {`BP_CS_N{1'b1}};
            done_reg  <= 1'b1;
            error_reg <= wait_is_ack && !wait_low;
            if (!is_write_reg) begin
              rdata_reg <= data_q;
            end
          end
        end
        `BP_ST_HOLD: begin
          state_reg   <= `BP_ST_IDLE;
          dout_oe_reg <= 1'b0;
          dir_n_reg   <= 1'b1;
        end
        `BP_ST_GRANT: begin
          if (!req_seen) begin
            state_reg   <= `BP_ST_IDLE;
            grant_n_reg <= 1'b1;
            bus_oe_reg  <= 1'b1;
          end
        end
        default: begin
          state_reg <= `BP_ST_IDLE;
        end
      endcase
    end
  end

  assign req_ready           = ready_reg;
  assign rsp_done            = done_reg;
  assign rsp_error           = error_reg;
  assign rsp_rdata           = rdata_reg;
  assign boot_cfg            = boot_reg;
  assign core_reset          = core_rst_reg;
  assign sdram_clock_ok      = fb_ok_reg;
  assign mem_addr_bus        = addr_reg;
  assign mem_bus_oe          = bus_oe_reg;
  assign mem_data_out        = dout_reg;
  assign mem_data_oe         = dout_oe_reg;
  assign xcvr_dir_n          = dir_n_reg;
  assign xcvr_out_en_n       = oe_n_reg;
  assign chip_select_n       = cs_n_reg;
  assign bus_grant_n         = grant_n_reg;
  assign warm_reset_io_n_out = warm_out_reg;
  assign warm_reset_io_n_oe  = warm_oe_reg;
  assign buffered_clock_out  = bclk_reg;

endmodule

`default_nettype wire

// file: core/bus_port_defs.vh
// Constants for the memory and peripheral bus port.
`ifndef BUS_PORT_DEFS_VH
`define BUS_PORT_DEFS_VH

// Bus widths.
`define BP_ADDR_W        26
`define BP_DATA_W        32
`define BP_CS_N          6
`define BP_CS_IDX_W      3
`define BP_MASK_W        4
`define BP_BOOT_W        8

// Address bits that carry module data mask enables in module mode.
`define BP_MASK_HI       20
`define BP_MASK_LO       17

// Positions in the synchronised control pin vector.
`define BP_PIN_REQ       0
`define BP_PIN_WAIT      1
`define BP_PIN_COLD      2
`define BP_PIN_WARM      3
`define BP_PIN_FB        4
`define BP_PIN_W         5
`define BP_PIN_INIT      5'b0_1111

// Access state codes.
`define BP_ST_IDLE       3'h0
`define BP_ST_SETUP      3'h1
`define BP_ST_STROBE     3'h2
`define BP_ST_HOLD       3'h3
`define BP_ST_GRANT      3'h4

// Timing.
`define BP_CLK_PERIOD_NS 10
`define BP_RST_HOLD_NS   1000
`define BP_RST_HOLD_CYC  ((`BP_RST_HOLD_NS + `BP_CLK_PERIOD_NS - 1) / `BP_CLK_PERIOD_NS)
`define BP_GUARD_CYC     4
`define BP_ACCESS_MIN    2
`define BP_ACK_TIMEOUT   255
`define BP_FB_TIMEOUT    16
`define BP_CNT_W         8

`endif

// file: core/pin_sync.v
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always @(posedge clk) begin
    if (reset) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

`default_nettype wire

// file: core/pulse_stretch.v
// Holds a level active while its trigger is high and a fixed count afterwards.
`timescale 1ns/10ps
`default_nettype none

module pulse_stretch #(
  parameter HOLD = 4,
  parameter CW   = 8
) (
  input  wire clk,
  input  wire reset,
  input  wire trigger,
  output wire active
);

  localparam [CW-1:0] HOLD_C = HOLD[CW-1:0];

  reg [CW-1:0] cnt_reg;
  reg          active_reg;

  // Reset counts as a trigger, so the level is active from reset onward.
  always @(posedge clk) begin
    if (reset || trigger) begin
      cnt_reg    <= HOLD_C;
      active_reg <= 1'b1;
    end else if (cnt_reg != {CW{1'b0}}) begin
      cnt_reg    <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
      active_reg <= 1'b1;
    end else begin
      active_reg <= 1'b0;
    end
  end

  assign active = active_reg;

endmodule

`default_nettype wire

// file: dv/bus_port_assertions.sv
// Pin-level checks for the memory and peripheral bus port.
`timescale 1ns/10ps
`default_nettype none
module bus_port_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wait_is_ack,
  input wire logic       req_ready,
  input wire logic       rsp_done,
  input wire logic       mem_bus_oe,
  input wire logic       xcvr_dir_n,
  input wire logic [1:0] xcvr_out_en_n,
  input wire logic [5:0] chip_select_n,
  input wire logic       bus_request_n,
  input wire logic       bus_grant_n,
  input wire logic       wait_or_ack_n,
  input wire logic       warm_reset_io_n_out,
  input wire logic       warm_reset_io_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Transceiver, select, grant and reset pin relations.
  property p_dir_read; xcvr_out_en_n != 2'b11 |-> !xcvr_dir_n; endproperty
  property p_oe_dev; !xcvr_out_en_n[0] |-> chip_select_n != 6'h3f; endproperty
  property p_oe_sdram; !xcvr_out_en_n[1] |-> chip_select_n == 6'h3f && xcvr_out_en_n[0];
  endproperty
  property p_one_cs; $onehot0(~chip_select_n); endproperty
  property p_grant_off; !bus_grant_n |-> !mem_bus_oe && chip_select_n == 6'h3f && !req_ready;
  endproperty
  property p_grant_hold; !bus_grant_n && !bus_request_n |=> !bus_grant_n; endproperty
  property p_wait_hold; (!wait_is_ack && !wait_or_ack_n) [*4] |-> !rsp_done; endproperty
  property p_pin_drive; warm_reset_io_n_oe |-> !warm_reset_io_n_out && !req_ready; endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction high during read");
  a_oe_dev: assert property (p_oe_dev) else $error("device enable without select");
  a_oe_sdram: assert property (p_oe_sdram) else $error("sdram enable with select");
  a_one_cs: assert property (p_one_cs) else $error("more than one select low");
  a_grant_off: assert property (p_grant_off) else $error("bus driven while granted");
  a_grant_hold: assert property (p_grant_hold) else $error("grant dropped early");
  a_wait_hold: assert property (p_wait_hold) else $error("done while wait low");
  a_pin_drive: assert property (p_pin_drive) else $error("reset pin misdriven");
  c_read: cover property (rsp_done && !xcvr_dir_n);
  c_grant: cover property ($fell(bus_grant_n));
  c_sdram: cover property (!xcvr_out_en_n[1]);
endmodule
bind memory_peripheral_bus_port bus_port_checker i_chk (.clk, .reset, .wait_is_ack, .req_ready,
  .rsp_done, .mem_bus_oe, .xcvr_dir_n, .xcvr_out_en_n, .chip_select_n, .bus_request_n,
  .bus_grant_n, .wait_or_ack_n, .warm_reset_io_n_out, .warm_reset_io_n_oe);
`default_nettype wire

// file: dv/bus_partner_model.sv
// Behavioural memory and peripheral device on the far side of the bus port.
`timescale 1ns/10ps
`default_nettype none
module bus_partner_model (
  input  wire logic        clk,
  input  wire logic        ack_mode,
  input  wire logic [8:0]  delay,
  input  wire logic [25:0] mem_addr_bus,
  input  wire logic [5:0]  chip_select_n,
  input  wire logic        xcvr_dir_n,
  input  wire logic [31:0] mem_data_out,
  input  wire logic        mem_data_oe,
  output wire logic [31:0] mem_data_in,
  output wire logic        wait_or_ack_n
);
  logic [31:0] mem [16];
  logic [31:0] last = 32'h0000_0000;
  int          cnt = 0;
  wire logic   active = chip_select_n != 6'h3f || !xcvr_dir_n || mem_data_oe;
  // Stores written words, remembers the last driven word and times the access.
  always @(posedge clk) begin
    if (mem_data_oe) mem[mem_addr_bus[3:0]] <= mem_data_out;
    if (!xcvr_dir_n) last <= mem_data_in;
    cnt <= active ? cnt + 1 : 0;
  end
  // Drives the stored word while the direction points inward, else the inverse of the last word, so a released bus never looks valid.
  assign mem_data_in = !xcvr_dir_n ? mem[mem_addr_bus[3:0]] : ~last;
  // Wait is held low for the first cycles, or the acknowledge comes after them.
  assign wait_or_ack_n = ack_mode ? !(active && cnt >= delay) : !(active && cnt < delay);
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking testbench for the memory and peripheral bus port.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_sdram = 1'b0;
  logic        sodimm_mode = 1'b0, wait_is_ack = 1'b0, bus_request_n = 1'b1;
  logic        cold_reset_n = 1'b1, ext_warm_n = 1'b1;
  logic [2:0]  req_cs = 3'h0;
  logic [3:0]  req_mask = 4'h0;
  logic [7:0]  boot_strap = 8'h00;
  logic [8:0]  delay = 9'h000;
  logic [25:0] req_addr = 26'h000_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  wire logic        req_ready, rsp_done, rsp_error, core_reset, sdram_clock_ok, mem_bus_oe;
  wire logic        mem_data_oe, xcvr_dir_n, bus_grant_n, wait_or_ack_n, buffered_clock_out;
  wire logic        warm_reset_io_n_out, warm_reset_io_n_oe, warm_pin;
  wire logic [1:0]  xcvr_out_en_n;
  wire logic [5:0]  chip_select_n;
  wire logic [7:0]  boot_cfg;
  wire logic [25:0] mem_addr_bus;
  wire logic [31:0] rsp_rdata, mem_data_in, mem_data_out;
  int               num_errors = 0, total_checks = 0, lat, lat0;

  // Reset pin resolves to the pull-up unless someone drives it low.
  assign warm_pin = (warm_reset_io_n_oe && !warm_reset_io_n_out) || !ext_warm_n ? 1'b0 : 1'b1;

  memory_peripheral_bus_port #(.ACK_TIMEOUT(20), .RST_HOLD(4)) i_dut (
    .clk, .reset, .req_valid, .req_write, .req_sdram, .req_cs, .req_addr, .req_wdata, .req_mask,
    .req_ready, .rsp_done, .rsp_error, .rsp_rdata, .sodimm_mode, .wait_is_ack, .boot_strap,
    .boot_cfg, .core_reset, .sdram_clock_ok, .mem_addr_bus, .mem_bus_oe, .mem_data_in,
    .mem_data_out, .mem_data_oe, .xcvr_dir_n, .xcvr_out_en_n, .chip_select_n, .bus_request_n,
    .bus_grant_n, .wait_or_ack_n, .cold_reset_n, .warm_reset_io_n_in(warm_pin),
    .warm_reset_io_n_out, .warm_reset_io_n_oe, .buffered_clock_out,
    .sdram_clock_feedback(buffered_clock_out));

  bus_partner_model i_mem (.clk, .ack_mode(wait_is_ack), .delay, .mem_addr_bus, .chip_select_n,
    .xcvr_dir_n, .mem_data_out, .mem_data_oe, .mem_data_in, .wait_or_ack_n);

  // Free-running clock.
  always #5 clk = ~clk;

  // Compares one value and counts the result.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for the port to become idle, then a few quiet cycles.
  task automatic wait_ready;
    for (lat = 0; lat < 500 && req_ready !== 1'b1; lat++) @(negedge clk);
    check("ready", req_ready, 1);
    repeat (3) @(negedge clk);
  endtask

  // One access: checks the pins at take and setup, then waits for completion.
  task automatic access(input logic wr, input logic sd, input logic [2:0] cs,
                        input logic [25:0] a, input logic [31:0] wd);
    wait_ready();
    req_valid = 1'b1;
    req_write = wr;
    req_sdram = sd;
    req_cs = cs;
    req_addr = a;
    req_wdata = wd;
    @(negedge clk);
    req_valid = 1'b0;
    check("select", chip_select_n, sd ? 6'h3f : 6'h3f ^ (6'h01 << cs));
    check("direction", xcvr_dir_n, wr);
    check("address", mem_addr_bus, sd && sodimm_mode ? {a[25:21], req_mask, a[16:0]} : a);
    @(negedge clk);
    check("out_enable", xcvr_out_en_n, wr ? 2'b11 : sd ? 2'b01 : 2'b10);
    for (lat = 2; lat < 400 && rsp_done !== 1'b1; lat++) @(negedge clk);
    check("done", rsp_done, 1);
  endtask

  // Write then read back every chip select.
  task automatic t_basic;
    for (int i = 0; i < 6; i++) begin
      access(1'b1, 1'b0, i[2:0], 26'h015_0000 + i[25:0], 32'hc0de_0000 + i);
      access(1'b0, 1'b0, i[2:0], 26'h015_0000 + i[25:0], 32'h0000_0000);
      check("read_data", rsp_rdata, 32'hc0de_0000 + i);
    end
    lat0 = lat;
    $display("test basic done");
  endtask

  // SDRAM traffic with mask enables on the address.
  task automatic t_sdram;
    sodimm_mode = 1'b1;
    req_mask = 4'h5;
    access(1'b1, 1'b1, 3'h0, 26'h015_0003, 32'h5d5d_a0a0);
    access(1'b0, 1'b1, 3'h0, 26'h015_0003, 32'h0000_0000);
    check("sdram_data", rsp_rdata, 32'h5d5d_a0a0);
    access(1'b0, 1'b0, 3'h3, 26'h015_0003, 32'h0000_0000);
    check("device_data", rsp_rdata, 32'h5d5d_a0a0);
    sodimm_mode = 1'b0;
    access(1'b0, 1'b1, 3'h0, 26'h015_0003, 32'h0000_0000);
    check("plain_sdram", rsp_rdata, 32'h5d5d_a0a0);
    $display("test sdram done");
  endtask

  // Wait stretching, acknowledge and acknowledge timeout.
  task automatic t_wait_ack;
    delay = 9'h006;
    access(1'b0, 1'b0, 3'h2, 26'h015_0002, 32'h0000_0000);
    check("stretched", lat > lat0, 1);
    wait_is_ack = 1'b1;
    delay = 9'h004;
    access(1'b0, 1'b0, 3'h4, 26'h015_0004, 32'h0000_0000);
    check("ack_data", {rsp_error, rsp_rdata[30:0]}, 32'h40de_0004);
    delay = 9'h12c;
    access(1'b0, 1'b0, 3'h4, 26'h015_0004, 32'h0000_0000);
    check("ack_timeout", rsp_error, 1);
    wait_is_ack = 1'b0;
    $display("test wait_ack done");
  endtask

  // Bus request during an access, grant, hold and release.
  task automatic t_grant;
    delay = 9'h00a;
    fork
      access(1'b0, 1'b0, 3'h1, 26'h015_0001, 32'h0000_0000);
      begin
        repeat (6) @(negedge clk);
        bus_request_n = 1'b0;
      end
    join
    check("grant_late", bus_grant_n, 1);
    for (lat = 0; lat < 20 && bus_grant_n !== 1'b0; lat++) @(negedge clk);
    check("granted", {bus_grant_n, mem_bus_oe, req_ready}, 0);
    repeat (8) @(negedge clk);
    check("grant_hold", bus_grant_n, 0);
    bus_request_n = 1'b1;
    for (lat = 0; lat < 20 && bus_grant_n !== 1'b1; lat++) @(negedge clk);
    check("released", {bus_grant_n, mem_bus_oe}, 2'b11);
    delay = 9'h000;
    $display("test grant done");
  endtask

  // Cold and warm reset, reset pin and clock copy.
  task automatic t_resets;
    logic b;
    boot_strap = 8'ha5;
    cold_reset_n = 1'b0;
    repeat (6) @(negedge clk);
    check("cold", {core_reset, warm_reset_io_n_oe, warm_pin}, 3'b110);
    cold_reset_n = 1'b1;
    wait_ready();
    check("boot", {warm_pin, boot_cfg}, 9'h1a5);
    repeat (6) @(negedge clk);
    ext_warm_n = 1'b0;
    repeat (6) @(negedge clk);
    check("warm", core_reset, 1);
    ext_warm_n = 1'b1;
    wait_ready();
    check("warm_done", {warm_pin, req_ready}, 2'b11);
    b = buffered_clock_out;
    @(negedge clk);
    check("clock_copy", {buffered_clock_out, sdram_clock_ok}, {!b, 1'b1});
    $display("test resets done");
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (21) @(negedge clk);
    reset = 1'b0;
    t_basic();
    t_sdram();
    t_wait_ack();
    t_grant();
    t_resets();
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
